// ### rtl/clkgen_pkg.sv
// Constants shared by the clock generator controller
package clkgen_pkg;
  localparam logic [31:0] ADDR_CSR     = 32'h01B7C100;
  localparam logic [31:0] ADDR_MULT    = 32'h01B7C110;
  localparam logic [31:0] ADDR_PRE     = 32'h01B7C114;
  localparam logic [31:0] ADDR_CORE    = 32'h01B7C118;
  localparam logic [31:0] ADDR_BUS     = 32'h01B7C11C;
  localparam logic [31:0] ADDR_MEMIF   = 32'h01B7C120;
  localparam logic [31:0] ADDR_OSC     = 32'h01B7C124;
  localparam int          CSR_PATH_BIT = 0;
  localparam int          CSR_PDN_BIT  = 1;
  localparam int          CSR_RST_BIT  = 3;
  localparam int          CSR_STB_BIT  = 6;
  localparam int          DIV_EN_BIT   = 15;
  localparam int          FIELD_W      = 5;
  localparam logic [4:0]  MULT_MIN     = 5'h04;
  localparam logic [4:0]  MULT_MAX     = 5'h19;
  localparam logic [4:0]  MULT_RESET   = 5'h00;
  localparam logic [4:0]  PRE_RESET    = 5'h00;
  localparam logic [4:0]  CORE_RESET   = 5'h00;
  localparam logic [4:0]  BUS_RESET    = 5'h01;
  localparam logic [4:0]  MEMIF_RESET  = 5'h01;
  localparam logic [4:0]  OSC_RESET    = 5'h07;
  // Input settle count, chosen; longer than the 3750-cycle bench lock time
  localparam logic [11:0] STABLE_COUNT = 12'hFFF;
endpackage

// ### rtl/clk_ratio_div.sv
// Glitch-free ratio divider producing a one-cycle tick every ratio+1 input ticks
`timescale 1ns/1ps
module clk_ratio_div
  import clkgen_pkg::*;
#(
  parameter logic [4:0] RESET_RATIO = 5'h00
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         tick_in,
  input  wire logic         enable,
  input  wire logic [4:0]   ratio,
  output logic              tick_out
);
  logic [4:0] count_r;
  logic [4:0] ratio_r;
  logic       wrap;

  assign wrap = (count_r == ratio_r);

  // Ratio reloads only at a period boundary or while disabled, so no runt pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r  <= 5'h00;
      ratio_r  <= RESET_RATIO;
      tick_out <= 1'b0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        count_r  <= 5'h00;
        ratio_r  <= ratio;
        tick_out <= 1'b0;
      end
      else if (tick_in)
      begin
        count_r  <= wrap ? 5'h00 : count_r + 5'h01;
        ratio_r  <= wrap ? ratio : ratio_r;
        tick_out <= wrap;
      end
      else
      begin
        tick_out <= 1'b0;
      end
    end
  end
endmodule // clk_ratio_div

// ### rtl/clkgen_ctrl.sv
// Loop controller registers and system clock dividers
`timescale 1ns/1ps
module clkgen_ctrl
  import clkgen_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [31:0]  reg_addr,
  input  wire logic [31:0]  reg_wdata,
  output logic [31:0]       reg_rdata,
  output logic              reg_rvalid,
  input  wire logic         pll_out_tick,
  output logic              pll_reset,
  output logic              pll_power_down,
  output logic              pll_path,
  output logic [4:0]        pll_mult,
  output logic              pll_mult_ok,
  output logic              pll_ref_tick,
  output logic              core_clock,
  output logic              peripheral_bus_clock,
  output logic              memory_if_clock,
  output logic              osc_clock_output
);
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [2:0]  pll_sync_r;
  logic [11:0] stable_cnt_r;
  logic        stable_r;
  logic        rst_bit_r;
  logic        pdn_bit_r;
  logic        path_r;
  logic [4:0]  mult_r;
  logic        mult_ok_r;
  logic [4:0]  ratio_r [0:4];
  logic        en_r    [0:4];
  logic        tick_q  [0:4];
  logic [31:0] rdata_r;
  logic        rvalid_r;
  logic        pll_tick;
  logic        ref_tick;
  logic        wr_csr;
  logic        wr_mult;
  logic [31:0] rd_mux;

  // Index of divider register, 7 when not a divider
  function automatic logic [2:0] div_index(input logic [31:0] a);
    case (a)
      ADDR_PRE:   div_index = 3'h0;
      ADDR_CORE:  div_index = 3'h1;
      ADDR_BUS:   div_index = 3'h2;
      ADDR_MEMIF: div_index = 3'h3;
      ADDR_OSC:   div_index = 3'h4;
      default:    div_index = 3'h7;
    endcase
  endfunction

  function automatic logic [31:0] div_word(input logic en, input logic [4:0] r);
    div_word = 32'h00000000;
    div_word[DIV_EN_BIT] = en;
    div_word[FIELD_W-1:0] = r;
  endfunction

  localparam logic [4:0] RESET_RATIOS [0:4] = '{PRE_RESET, CORE_RESET, BUS_RESET, MEMIF_RESET, OSC_RESET};

  assign rst_n   = rst_sync_r[1];
  assign wr_csr  = reg_wr && (reg_addr == ADDR_CSR);
  assign wr_mult = reg_wr && (reg_addr == ADDR_MULT);
  // Loop output edge seen on the settled copy only
  assign pll_tick = pll_sync_r[1] && !pll_sync_r[2];
  assign ref_tick = path_r ? pll_tick : 1'b1;

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (reg_addr == ADDR_CSR)
    begin
      rd_mux[CSR_PATH_BIT] = path_r;
      rd_mux[CSR_PDN_BIT]  = pdn_bit_r;
      rd_mux[CSR_RST_BIT]  = rst_bit_r;
      rd_mux[CSR_STB_BIT]  = stable_r;
    end
    else if (reg_addr == ADDR_MULT)
      rd_mux[FIELD_W-1:0] = mult_r;
    else if (div_index(reg_addr) != 3'h7)
      rd_mux = div_word(en_r[div_index(reg_addr)], ratio_r[div_index(reg_addr)]);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_sync_r   <= 3'b000;
      stable_cnt_r <= 12'h000;
      stable_r     <= 1'b0;
      rst_bit_r    <= 1'b1;
      pdn_bit_r    <= 1'b0;
      path_r       <= 1'b0;
      mult_r       <= MULT_RESET;
      mult_ok_r    <= 1'b0;
      rdata_r      <= 32'h00000000;
      rvalid_r     <= 1'b0;
    end
    else if (ce)
    begin
      pll_sync_r <= {pll_sync_r[1:0], pll_out_tick};
      if (stable_cnt_r != STABLE_COUNT)
        stable_cnt_r <= stable_cnt_r + 12'h001;
      stable_r <= (stable_cnt_r == STABLE_COUNT);
      if (wr_csr)
      begin
        rst_bit_r <= reg_wdata[CSR_RST_BIT];
        pdn_bit_r <= reg_wdata[CSR_PDN_BIT];
        path_r    <= reg_wdata[CSR_PATH_BIT];
      end
      if (wr_mult)
        mult_r <= reg_wdata[FIELD_W-1:0];
      // Reserved codes are kept but flagged for the analog loop
      mult_ok_r <= (mult_r >= MULT_MIN) && (mult_r <= MULT_MAX);
      rdata_r  <= reg_rd ? rd_mux : 32'h00000000;
      rvalid_r <= reg_rd;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_div
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          en_r[g]    <= 1'b1;
          ratio_r[g] <= RESET_RATIOS[g];
        end
        else if (ce && reg_wr && (div_index(reg_addr) == 3'(g)))
        begin
          en_r[g]    <= reg_wdata[DIV_EN_BIT];
          ratio_r[g] <= reg_wdata[FIELD_W-1:0];
        end
      end
    end
  endgenerate

  // Prescaler feeds only the loop reference; osc divider sees raw input ticks
  clk_ratio_div #(.RESET_RATIO(PRE_RESET)) u_pre (
    .clk(clk), .rst_n(rst_n), .ce(ce), .tick_in(1'b1), .enable(en_r[0]),
    .ratio(ratio_r[0]), .tick_out(tick_q[0]));
  clk_ratio_div #(.RESET_RATIO(CORE_RESET)) u_core (
    .clk(clk), .rst_n(rst_n), .ce(ce), .tick_in(ref_tick), .enable(en_r[1]),
    .ratio(ratio_r[1]), .tick_out(tick_q[1]));
  clk_ratio_div #(.RESET_RATIO(BUS_RESET)) u_bus (
    .clk(clk), .rst_n(rst_n), .ce(ce), .tick_in(ref_tick), .enable(en_r[2]),
    .ratio(ratio_r[2]), .tick_out(tick_q[2]));
  clk_ratio_div #(.RESET_RATIO(MEMIF_RESET)) u_memif (
    .clk(clk), .rst_n(rst_n), .ce(ce), .tick_in(ref_tick), .enable(en_r[3]),
    .ratio(ratio_r[3]), .tick_out(tick_q[3]));
  clk_ratio_div #(.RESET_RATIO(OSC_RESET)) u_osc (
    .clk(clk), .rst_n(rst_n), .ce(ce), .tick_in(1'b1), .enable(en_r[4]),
    .ratio(ratio_r[4]), .tick_out(tick_q[4]));

  assign reg_rdata            = rdata_r;
  assign reg_rvalid           = rvalid_r;
  assign pll_reset            = rst_bit_r;
  assign pll_power_down       = pdn_bit_r;
  assign pll_path             = path_r;
  assign pll_mult             = mult_r;
  assign pll_mult_ok          = mult_ok_r;
  assign pll_ref_tick         = tick_q[0];
  assign core_clock           = tick_q[1];
  assign peripheral_bus_clock = tick_q[2];
  assign memory_if_clock      = tick_q[3];
  assign osc_clock_output     = tick_q[4];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_stable_rise: assert property (ce && !stable_r && stable_cnt_r == STABLE_COUNT |=> stable_r)
    else $error("stable bit did not rise after count");
  chk_stable_early: assert property (stable_r |-> stable_cnt_r == STABLE_COUNT)
    else $error("stable bit set before count finished");
  chk_loop_reset: assert property (ce && wr_csr |=> pll_reset == $past(reg_wdata[CSR_RST_BIT]))
    else $error("loop reset does not follow write");
  chk_power_down: assert property (ce && wr_csr |=> pll_power_down == $past(reg_wdata[CSR_PDN_BIT]))
    else $error("power-down does not follow write");
  // Enabled divider loads a new ratio only at wrap, so one tick must prove the reload
  logic bypass_div1;
  assign bypass_div1 = ce && !path_r && en_r[1] && (ratio_r[1] == 5'h00);
  chk_bypass_ref: assert property (bypass_div1 ##1 bypass_div1 && core_clock |=> core_clock)
    else $error("bypass divide-by-1 core clock missed a tick");
  chk_mult_range: assert property (ce |=> pll_mult_ok == ($past(mult_r) >= MULT_MIN && $past(mult_r) <= MULT_MAX))
    else $error("multiplier range flag wrong");
  chk_div_off: assert property (ce && !en_r[3] |=> !memory_if_clock)
    else $error("disabled divider produced a tick");
  chk_osc_enable: assert property (ce && reg_wr && reg_addr == ADDR_OSC |=> en_r[4] == $past(reg_wdata[DIV_EN_BIT]))
    else $error("osc enable does not follow write");
  chk_osc_gap: assert property (ce && osc_clock_output && $past(ratio_r[4]) != 5'h00 |=> !osc_clock_output)
    else $error("osc divider ticked back to back");
  chk_reserved_zero: assert property (reg_rvalid |-> reg_rdata[31:16] == 16'h0000 && reg_rdata[14:7] == 8'h00)
    else $error("reserved bits read nonzero");

  cov_path_on: cover property (ce && wr_csr && reg_wdata[CSR_PATH_BIT]);
  cov_stable: cover property ($rose(stable_r));
  cov_core_tick: cover property (path_r && core_clock);
endmodule // clkgen_ctrl

// ### sim/clkgen_ctrl_tb.sv
// Self-checking bench for the clock generator controller
`timescale 1ns/1ps
module clkgen_ctrl_tb;
  import clkgen_pkg::*;
  // Maximum lock time in 50 ns cycles
  localparam int LOCK_CYCLES = 3750;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        loop_tick;
  logic        loop_run;
  logic        pll_reset;
  logic        pll_power_down;
  logic        pll_path;
  logic [4:0]  pll_mult;
  logic        pll_mult_ok;
  logic [4:0]  tap;
  int          miscompares;
  int          n_tests;
  logic [31:0] addrs [7];
  logic [31:0] resets [7];
  logic [4:0]  codes [4];
  logic [31:0] oks [4];

  clkgen_ctrl DUT (
    .clk                  (clk),
    .rstn                 (rstn),
    .ce                   (ce),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .reg_rvalid           (reg_rvalid),
    .pll_out_tick         (loop_tick),
    .pll_reset            (pll_reset),
    .pll_power_down       (pll_power_down),
    .pll_path             (pll_path),
    .pll_mult             (pll_mult),
    .pll_mult_ok          (pll_mult_ok),
    .pll_ref_tick         (tap[4]),
    .core_clock           (tap[0]),
    .peripheral_bus_clock (tap[1]),
    .memory_if_clock      (tap[2]),
    .osc_clock_output     (tap[3])
  );

  always #25 clk = ~clk;

  // Loop output model, rising edge every two cycles
  always @(negedge clk)
    if (loop_run)
      loop_tick <= ~loop_tick;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic expire();
    miscompares++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    int i;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++)
      @(negedge clk);
    if (reg_rvalid !== 1'b1)
      expire();
    check(reg_rdata, exp);
  endtask

  // Third gap measured; earlier ones may still use the old ratio
  task automatic period(input int sel, input int exp);
    int i;
    for (int n = 0; n < 3; n++)
    begin
      i = 0;
      do
      begin
        @(negedge clk);
        i++;
      end while (tap[sel] !== 1'b1 && i < 200);
      if (i >= 200)
        expire();
    end
    check(32'(i), 32'(exp));
  endtask

  task automatic quiet(input int sel);
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk);
      check({31'h0, tap[sel]}, 32'h0);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    loop_tick = 1'b0;
    loop_run = 1'b0;
    miscompares = 0;
    n_tests = 0;
    addrs = '{ADDR_CSR, ADDR_MULT, ADDR_PRE, ADDR_CORE, ADDR_BUS, ADDR_MEMIF, ADDR_OSC};
    resets = '{32'h8, 32'h0, 32'h8000, 32'h8000, 32'h8001, 32'h8001, 32'h8007};
    codes = '{5'h03, 5'h04, 5'h19, 5'h1A};
    oks = '{32'h0, 32'h1, 32'h1, 32'h0};
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check({29'h0, pll_reset, pll_power_down, pll_path}, 32'h4);
    for (int k = 0; k < 7; k++)
      rdc(addrs[k], resets[k]);
    rdc(32'h01B7C104, 32'h0);
    wr(ADDR_MULT, 32'hFFFFFFFF);
    rdc(ADDR_MULT, 32'h1F);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_MULT, {27'h0, codes[k]});
      check({27'h0, pll_mult}, {27'h0, codes[k]});
      @(negedge clk);
      check({31'h0, pll_mult_ok}, oks[k]);
    end
    // Clock enable low: the write must not land
    ce = 1'b0;
    wr(ADDR_MULT, 32'h00000005);
    check({27'h0, pll_mult}, 32'h0000001A);
    ce = 1'b1;
    wr(ADDR_CSR, 32'hFFFFFFFB);
    rdc(ADDR_CSR, 32'hB);
    check({29'h0, pll_reset, pll_power_down, pll_path}, 32'h7);
    wr(ADDR_CSR, 32'h8);
    check({29'h0, pll_reset, pll_power_down, pll_path}, 32'h4);
    // Slowing: bus divider before core, bus kept at half the core rate or slower
    wr(ADDR_BUS, 32'hFFFFFFFF);
    wr(ADDR_PRE, 32'hFFFFFFFF);
    wr(ADDR_CORE, 32'hFFFFFFEF);
    wr(ADDR_MEMIF, 32'hFFFFFFFF);
    wr(ADDR_OSC, 32'hFFFFFFFF);
    for (int k = 2; k < 7; k++)
      rdc(addrs[k], (k == 3) ? 32'h800F : 32'h801F);
    // Speeding up: core divider before bus
    wr(ADDR_CORE, 32'h8004);
    wr(ADDR_BUS, 32'h8009);
    wr(ADDR_MEMIF, 32'h0002);
    wr(ADDR_OSC, 32'h8002);
    wr(ADDR_PRE, 32'h8002);
    period(0, 5);
    period(1, 10);
    period(3, 3);
    quiet(2);
    loop_run = 1'b1;
    wr(ADDR_CSR, 32'h0);
    // Full lock time in bypass before the path switch
    repeat (LOCK_CYCLES) @(negedge clk);
    wr(ADDR_CSR, 32'h1);
    check({29'h0, pll_reset, pll_power_down, pll_path}, 32'h1);
    period(0, 10);
    period(1, 20);
    period(3, 3);
    period(4, 3);
    wr(ADDR_OSC, 32'h00000002);
    quiet(3);
    repeat (4200) @(negedge clk);
    rdc(ADDR_CSR, 32'h41);
    summarize();
  end
endmodule // clkgen_ctrl_tb
